// >>> hdl/alu_barrel_shifter_flags.sv
// ALU and barrel shifter datapath with registered result and status flags.
// Assumes decoder and register file inputs are synchronous to clock_in.
//
// Function
// - Codes 0,1,C,E: and, xor, or, bit clear.
// - Code 2 subtracts, code 3 reverse-subtracts.
// - Code 4 adds, code 5 adds carry too.
// - Codes 6,7 subtract or reverse-subtract with carry.
// - Codes 8 to B compute without writing result.
// - Code D moves operand 2, F inverts it.
// - Flags change only on update, non-PC destination.
// - Logical: V kept, C from shifter, Z, N.
// - Arithmetic 32-bit; V on signed overflow.
// - Arithmetic carry from adder bit 31.
// - Arithmetic Z on zero result, N bit 31.
// - Shift kind field picks four shift kinds.
// - Immediate shift amount is five bits.
// - Left shift zero-fills, carry last discarded bit.
// - Left shift zero passes operand, old carry.
// - Logical right shift zero-fills high bits.
// - Immediate right zero means shift by 32.
// - Arithmetic right fills with sign bit.
// - Immediate arithmetic zero means shift by 32.
// - Rotate right wraps low bits to top.
// - Immediate rotate zero is 33-bit extended rotate.
// - Register amount low byte; zero passes operand.
// - Register logical shifts 32 and beyond.
// - Register arithmetic and rotate beyond 32.
`timescale 1ns/1ps

`include "alu_params.svh"

module alu_barrel_shifter_flags #(
    parameter int DATA_WIDTH = `DATA_WIDTH
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic op_valid_in,
    input wire logic [3:0] opcode_in,
    input wire logic [31:0] first_operand_reg_in,
    input wire logic [31:0] shifted_source_reg_in,
    input wire alu_pkg::shift_req_t shift_req_in,
    input wire logic flag_update_bit_in,
    input wire logic dest_is_pc_in,
    output logic [31:0] result_out,
    output logic result_write_out,
    output logic result_valid_out,
    output alu_pkg::status_flags_t status_word_out
);

    // The datapath is built for one word width only, with the sign at its top bit;
    // refusing other values at elaboration beats a silently truncated adder
    if ((DATA_WIDTH != `DATA_WIDTH) || (`SIGN_BIT != DATA_WIDTH - 1))
    begin : g_width_check
        $error("alu_barrel_shifter_flags supports only a 32-bit data path");
    end

    alu_pkg::status_flags_t flags_q;
    alu_pkg::status_flags_t flags_d;
    logic [31:0] result_q;
    logic write_q;
    logic valid_q;

    logic [7:0] amount;
    logic extend_sel;
    logic pass_sel;
    logic [32:0] wide_left;
    logic [32:0] wide_right;
    logic [32:0] wide_arith;
    logic [31:0] rotated;
    logic [4:0] rot_amount;
    logic [31:0] operand2;
    logic shift_carry;

    logic [31:0] add_a;
    logic [31:0] add_b;
    logic add_cin;
    logic [32:0] sum;
    logic arith_class;
    logic [31:0] alu_result;
    logic [31:0] logic_result;
    logic result_zero;
    logic flag_write;

    // Effective shift amount; immediate zero on right shifts encodes 32 or the extended rotate
    always_comb
    begin
        amount = 8'h00;
        extend_sel = 1'b0;
        pass_sel = 1'b0;
        if (shift_req_in.by_reg)
        begin
            amount = shift_req_in.amount_reg[7:0];
            pass_sel = (amount == 8'h00);
        end
        else
        begin
            amount = {3'b000, shift_req_in.imm_amount};
            if (shift_req_in.imm_amount == 5'h00)
            begin
                case (shift_req_in.kind)
                    `SHIFT_LEFT_LOGICAL: pass_sel = 1'b1;
                    `SHIFT_ROTATE_RIGHT: extend_sel = 1'b1;
                    default: amount = 8'h20;
                endcase
            end
        end
    end

    // Shifts done 33 bits wide so the carry bit falls out of the same vector;
    // amounts above 32 give zero result and zero carry, but the arithmetic shift fills both with the sign.
    assign wide_left = {1'b0, shifted_source_reg_in} << amount;
    assign wide_right = {shifted_source_reg_in, 1'b0} >> amount;
    assign wide_arith = 33'($signed({shifted_source_reg_in, 1'b0}) >>> amount);
    assign rot_amount = amount[4:0];

    // Rotator built bit by bit: each result bit takes its source by index modulo the word,
    // so a rotate by a multiple of 32 returns the operand without any out-of-range shift
    for (genvar bit_idx = 0; bit_idx < `DATA_WIDTH; bit_idx++)
    begin : g_rotate
        assign rotated[bit_idx] = shifted_source_reg_in[5'(bit_idx + int'(rot_amount))];
    end

    // Barrel shifter output and shifter carry
    always_comb
    begin
        operand2 = shifted_source_reg_in;
        shift_carry = flags_q.carry;
        if (pass_sel)
        begin
            operand2 = shifted_source_reg_in;
            shift_carry = flags_q.carry;
        end
        else if (extend_sel)
        begin
            operand2 = {flags_q.carry, shifted_source_reg_in[31:1]};
            shift_carry = shifted_source_reg_in[0];
        end
        else
        begin
            case (shift_req_in.kind)
                `SHIFT_LEFT_LOGICAL:
                begin
                    operand2 = wide_left[31:0];
                    shift_carry = wide_left[32];
                end
                `SHIFT_RIGHT_LOGICAL:
                begin
                    operand2 = wide_right[32:1];
                    shift_carry = wide_right[0];
                end
                `SHIFT_RIGHT_ARITH:
                begin
                    operand2 = wide_arith[32:1];
                    shift_carry = wide_arith[0];
                end
                default:
                begin
                    operand2 = rotated;
                    shift_carry = rotated[`SIGN_BIT];
                end
            endcase
        end
    end

    // Adder operands; subtraction is addition of the inverse, so carry means no borrow
    always_comb
    begin
        add_a = first_operand_reg_in;
        add_b = operand2;
        add_cin = 1'b0;
        case (opcode_in)
            `OP_SUB, `OP_COMPARE:
            begin
                add_b = ~operand2;
                add_cin = 1'b1;
            end
            `OP_REVERSE_SUB:
            begin
                add_a = operand2;
                add_b = ~first_operand_reg_in;
                add_cin = 1'b1;
            end
            `OP_ADD_CARRY: add_cin = flags_q.carry;
            `OP_SUB_CARRY:
            begin
                add_b = ~operand2;
                add_cin = flags_q.carry;
            end
            `OP_REV_SUB_CARRY:
            begin
                add_a = operand2;
                add_b = ~first_operand_reg_in;
                add_cin = flags_q.carry;
            end
            default: add_cin = 1'b0;
        endcase
    end

    // Adder and operation class; codes 2 to 7, A and B are arithmetic
    assign sum = {1'b0, add_a} + {1'b0, add_b} + {32'h0000_0000, add_cin};
    assign arith_class = (opcode_in[3:1] == 3'b001) || (opcode_in[3:2] == 2'b01) || (opcode_in[3:1] == 3'b101);

    // Logical operations
    always_comb
    begin
        case (opcode_in)
            `OP_AND_OP, `OP_TEST_BITS: logic_result = first_operand_reg_in & operand2;
            `OP_XOR_OP, `OP_TEST_EQUIV: logic_result = first_operand_reg_in ^ operand2;
            `OP_INCLUSIVE_OR: logic_result = first_operand_reg_in | operand2;
            `OP_MOVE: logic_result = operand2;
            `OP_BIT_CLEAR: logic_result = first_operand_reg_in & ~operand2;
            `OP_MOVE_INVERTED: logic_result = ~operand2;
            default: logic_result = `RESULT_RESET;
        endcase
    end

    // Result selector between the adder and the logic unit
    assign alu_result = arith_class ? sum[31:0] : logic_result;

    // Zero detect shared by both flag classes
    assign result_zero = (alu_result == `RESULT_RESET);

    // Flags follow an operation only when asked to and the destination is not the PC
    assign flag_write = op_valid_in && flag_update_bit_in && !dest_is_pc_in;

    // Next flags: untouched unless the update bit is set and the destination is not the PC
    always_comb
    begin
        flags_d = flags_q;
        if (flag_write)
        begin
            flags_d.negative = alu_result[`SIGN_BIT];
            flags_d.zero = result_zero;
            if (arith_class)
            begin
                flags_d.carry = sum[32];
                flags_d.overflow = (add_a[31] == add_b[31]) && (sum[31] != add_a[31]);
            end
            else
            begin
                flags_d.carry = shift_carry;
                flags_d.overflow = flags_q.overflow; // overflow belongs to arithmetic codes only
            end
        end
    end

    // Status word register
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            flags_q <= `FLAGS_RESET;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    // Result register; it holds across idle cycles so the last answer stays on the port
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            result_q <= `RESULT_RESET;
        end
        else if (op_valid_in)
        begin
            result_q <= alu_result;
        end
    end

    // Write strobe; test and compare codes still produce a result but never request a write
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            write_q <= 1'b0;
        end
        else
        begin
            write_q <= op_valid_in && (opcode_in[3:2] != 2'b10);
        end
    end

    // Valid strobe: one pulse per taken operation, whether or not it writes
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            valid_q <= 1'b0;
        end
        else
        begin
            valid_q <= op_valid_in;
        end
    end

    // Outputs come straight from their registers
    assign result_out = result_q;
    assign result_write_out = write_q;
    assign result_valid_out = valid_q;
    assign status_word_out = flags_q;

endmodule : alu_barrel_shifter_flags

// >>> hdl/alu_params.svh
// Operation codes, shift kinds, field positions and reset values of the ALU datapath.
// Assumes the including file uses the names only as sized constants.
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH

// Operation codes
`define OP_AND_OP         4'h0
`define OP_XOR_OP         4'h1
`define OP_SUB            4'h2
`define OP_REVERSE_SUB    4'h3
`define OP_ADD            4'h4
`define OP_ADD_CARRY      4'h5
`define OP_SUB_CARRY      4'h6
`define OP_REV_SUB_CARRY  4'h7
`define OP_TEST_BITS      4'h8
`define OP_TEST_EQUIV     4'h9
`define OP_COMPARE        4'hA
`define OP_COMPARE_NEG    4'hB
`define OP_INCLUSIVE_OR   4'hC
`define OP_MOVE           4'hD
`define OP_BIT_CLEAR      4'hE
`define OP_MOVE_INVERTED  4'hF

// Shift type field encoding
`define SHIFT_LEFT_LOGICAL  2'h0
`define SHIFT_RIGHT_LOGICAL 2'h1
`define SHIFT_RIGHT_ARITH   2'h2
`define SHIFT_ROTATE_RIGHT  2'h3

// Data path geometry
`define DATA_WIDTH     32
`define SIGN_BIT       31
`define IMM_SHIFT_BITS 5
`define REG_SHIFT_BITS 8

// Reset values
`define FLAGS_RESET  4'h0
`define RESULT_RESET 32'h0000_0000

`endif

// >>> hdl/alu_pkg.sv
// Types shared by the ALU datapath and its surroundings.
// Constants live in alu_params.svh; this package holds types only.
package alu_pkg;

    // Condition flags of the status word
    typedef struct packed {
        logic negative;
        logic zero;
        logic carry;
        logic overflow;
    } status_flags_t;

    // Second-operand shift request from the instruction decoder
    typedef struct packed {
        logic [1:0] kind;
        logic by_reg;
        logic [4:0] imm_amount;
        logic [31:0] amount_reg;
    } shift_req_t;

endpackage : alu_pkg

// >>> tb/alu_checker.sv
// Port-level assertions on the ALU datapath.
// Assumes one clock and an active-high synchronous reset.
`timescale 1ns/1ps
module alu_checker (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic op_valid_in,
    input wire logic [3:0] opcode_in,
    input wire logic [31:0] shifted_source_reg_in,
    input wire alu_pkg::shift_req_t shift_req_in,
    input wire logic flag_update_bit_in,
    input wire logic dest_is_pc_in,
    input wire logic [31:0] result_out,
    input wire logic result_write_out,
    input wire logic result_valid_out,
    input wire alu_pkg::status_flags_t status_word_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // Flag update qualifier and logical class of the code
    logic upd;
    logic logc;
    logic imm0;
    assign upd = op_valid_in && flag_update_bit_in && !dest_is_pc_in;
    assign logc = opcode_in[3:1] == 3'h0 || opcode_in[3:1] == 3'h4 || opcode_in[3:2] == 2'h3;
    assign imm0 = op_valid_in && !shift_req_in.by_reg && shift_req_in.imm_amount == 5'h00;
    property p_no_wr; op_valid_in && opcode_in[3:2] == 2'h2 |=> !result_write_out; endproperty
    property p_wr; op_valid_in && opcode_in[3:2] != 2'h2 |=> result_write_out && result_valid_out; endproperty
    property p_hold; !upd |=> $stable(status_word_out); endproperty
    property p_keep_v; upd && logc |=> $stable(status_word_out.overflow); endproperty
    property p_zero; upd |=> status_word_out.zero == (result_out == 32'h0000_0000); endproperty
    property p_neg; upd |=> status_word_out.negative == result_out[31]; endproperty
    property p_mov0; imm0 && opcode_in == 4'hD && shift_req_in.kind == 2'h0
        |=> result_out == $past(shifted_source_reg_in) && status_word_out.carry == $past(status_word_out.carry);
    endproperty
    property p_inv32; imm0 && opcode_in == 4'hF && shift_req_in.kind == 2'h2
        |=> result_out == {32{!$past(shifted_source_reg_in[31])}}; endproperty
    a_no_wr: assert property (p_no_wr) else $error("test code wrote");
    a_wr: assert property (p_wr) else $error("write pulse missing");
    a_hold: assert property (p_hold) else $error("flags moved");
    a_keep_v: assert property (p_keep_v) else $error("overflow moved");
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    a_neg: assert property (p_neg) else $error("negative flag wrong");
    a_mov0: assert property (p_mov0) else $error("move by zero wrong");
    a_inv32: assert property (p_inv32) else $error("sign fill wrong");
    c_adc: cover property (upd && opcode_in == 4'h5);
    c_big: cover property (op_valid_in && shift_req_in.by_reg && shift_req_in.amount_reg[7:0] > 8'h20);
    c_log: cover property (upd && logc);
endmodule : alu_checker

bind alu_barrel_shifter_flags alu_checker chk (.clock_in(clock_in), .rst_in(rst_in),
    .op_valid_in(op_valid_in), .opcode_in(opcode_in), .shifted_source_reg_in(shifted_source_reg_in),
    .shift_req_in(shift_req_in), .flag_update_bit_in(flag_update_bit_in), .dest_is_pc_in(dest_is_pc_in),
    .result_out(result_out), .result_write_out(result_write_out), .result_valid_out(result_valid_out),
    .status_word_out(status_word_out));

// >>> tb/op_source_model.sv
// Decoder and register-file stand-in presenting one operation per call.
// Assumes issue is called right at a rising clock edge.
`timescale 1ns/1ps
module op_source_model (
    output logic op_valid_out,
    output logic [3:0] opcode_out,
    output logic [31:0] first_operand_out,
    output logic [31:0] source_out,
    output alu_pkg::shift_req_t shift_req_out,
    output logic flag_update_out,
    output logic dest_is_pc_out
);
    // Idle until the first call
    initial
    begin
        {op_valid_out, opcode_out, first_operand_out, source_out} = '0;
        {shift_req_out, flag_update_out, dest_is_pc_out} = '0;
    end
    // All fields move together so no half-updated operation is sampled
    task automatic issue(input logic v, input logic [3:0] o, input logic [31:0] a, input logic [31:0] s,
        input alu_pkg::shift_req_t q, input logic u, input logic p);
        op_valid_out <= v;
        opcode_out <= o;
        first_operand_out <= a;
        source_out <= s;
        shift_req_out <= q;
        flag_update_out <= u;
        dest_is_pc_out <= p;
    endtask : issue
endmodule : op_source_model

// >>> tb/tb_alu_barrel_shifter_flags.sv
// Self-checking bench: random operations against a behavioural ALU model.
// Assumes the datapath answers one cycle after each taken operation.
`timescale 1ns/1ps
module tb_alu_barrel_shifter_flags;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic v, fu, pc, wr, rv, ev, ew;
    logic [3:0] op;
    logic [31:0] a, s, res, er;
    alu_pkg::shift_req_t q;
    alu_pkg::status_flags_t fl, ef;
    int n_errors = 0;
    int num_checks = 0;
    int seed = 32'h7dc7_6638;

    always #10 clock_in = ~clock_in;

    alu_barrel_shifter_flags DUT (.clock_in(clock_in), .rst_in(rst_in), .op_valid_in(v), .opcode_in(op),
        .first_operand_reg_in(a), .shifted_source_reg_in(s), .shift_req_in(q), .flag_update_bit_in(fu),
        .dest_is_pc_in(pc), .result_out(res), .result_write_out(wr), .result_valid_out(rv), .status_word_out(fl));
    op_source_model src (.op_valid_out(v), .opcode_out(op), .first_operand_out(a), .source_out(s),
        .shift_req_out(q), .flag_update_out(fu), .dest_is_pc_out(pc));

    // Shifter reference, returns {carry, operand 2}
    function automatic logic [32:0] shf(input logic [31:0] x, input alu_pkg::shift_req_t r, input logic c);
        int n;
        logic signed [32:0] t;
        logic [63:0] w;
        n = r.by_reg ? int'(r.amount_reg[7:0]) : int'(r.imm_amount);
        if (n == 0 && !r.by_reg && r.kind != 2'h0)
        begin
            if (r.kind == 2'h3)
                return {x[0], c, x[31:1]};
            n = 32;
        end
        if (n == 0)
            return {c, x};
        case (r.kind)
            2'h0: return (n > 32) ? 33'h0 : {1'b0, x} << n;
            2'h1: t = (n > 32) ? 33'h0 : {x, 1'b0} >> n;
            2'h2: t = $signed({x, 1'b0}) >>> ((n > 32) ? 32 : n);
            default:
            begin
                w = {x, x} >> ((n - 1) % 32 + 1);
                return {w[31], w[31:0]};
            end
        endcase
        return {t[0], t[32:1]};
    endfunction : shf

    // Reference ALU step: sets expected result, strobes and flags
    task automatic model(input logic [3:0] o, input logic [31:0] x, input logic [32:0] b, input logic u);
        logic [31:0] p, m, y;
        logic [32:0] sum;
        logic ci, l;
        y = b[31:0];
        l = o[3:1] == 3'h0 || o[3:1] == 3'h4 || o[3:2] == 2'h3;
        ci = (o == 4'h2 || o == 4'h3 || o == 4'hA) ? 1'b1 : (o inside {4'h5, 4'h6, 4'h7}) && ef.carry;
        case (o)
            4'h0, 4'h8: er = x & y;
            4'h1, 4'h9: er = x ^ y;
            4'hC: er = x | y;
            4'hD: er = y;
            4'hE: er = x & ~y;
            4'hF: er = ~y;
            4'h2, 4'h6, 4'hA: {p, m} = {x, ~y};
            4'h3, 4'h7: {p, m} = {y, ~x};
            default: {p, m} = {x, y};
        endcase
        sum = {1'b0, p} + {1'b0, m} + {32'h0, ci};
        if (!l)
            er = sum[31:0];
        if (u)
        begin
            ef.negative = er[31];
            ef.zero = er == 32'h0000_0000;
            ef.carry = l ? b[32] : sum[32];
            if (!l)
                ef.overflow = p[31] == m[31] && er[31] != p[31];
        end
        ev = 1'b1;
        ew = o[3:2] != 2'h2;
    endtask : model

    // Comparisons share one counter and one report format
    task automatic tally(input logic ok, input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (!ok)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : tally
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        tally(g === e, g, e);
    endtask : chk_word
    task automatic chk_flags(input alu_pkg::status_flags_t g, input alu_pkg::status_flags_t e);
        tally(g === e, 32'(g), 32'(e));
    endtask : chk_flags
    task automatic chk_bit(input logic g, input logic e);
        tally(g === e, 32'(g), 32'(e));
    endtask : chk_bit

    // Issue at an edge, check the previous answer just after it
    task automatic step(input logic vv);
        alu_pkg::shift_req_t rq;
        logic [31:0] x, y;
        logic [3:0] o;
        logic u, p;
        rq = 40'({$random(seed), $random(seed)});
        if (rq.amount_reg[8])
            rq.amount_reg[7:0] &= 8'h3f; // Bias toward zero and the 32 boundary
        if (rq.imm_amount[4:2] == 3'h0)
            rq.imm_amount = 5'h00;
        {x, y} = {$random(seed), $random(seed)};
        o = 4'($random(seed));
        u = 1'($random(seed));
        p = 3'($random(seed)) == 3'h0;
        // About one operation in eight is a move by an immediate zero, so the special encodings are reached
        if (rq.amount_reg[31:29] == 3'h0)
        begin
            {rq.by_reg, rq.imm_amount} = 6'h00;
            rq.kind = {rq.amount_reg[28], 1'b0};
            o = {2'b11, rq.amount_reg[28], 1'b1}; // Move with left shift zero, inverted move with sign fill
        end
        @(posedge clock_in);
        src.issue(vv, o, x, y, rq, u, p);
        #1;
        chk_bit(rv, ev);
        chk_bit(wr, ew);
        chk_word(res, er);
        chk_flags(fl, ef);
        {ev, ew} = 2'h0;
        if (vv)
            model(o, x, shf(y, rq, ef.carry), u && !p);
    endtask : step

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // Each test restarts from reset; the last runs back to back
    initial
    begin
        for (int t = 0; t < 4; t++)
        begin
            @(posedge clock_in);
            rst_in <= 1'b1;
            src.issue(1'b0, 4'h0, '0, '0, '0, 1'b0, 1'b0);
            repeat (16) @(posedge clock_in);
            rst_in <= 1'b0;
            {ev, ew, er, ef} = '0;
            for (int i = 0; i < 500; i++)
                step(t == 3 || 3'($random(seed)) != 3'h0);
            $display("test %0d done, errors %0d", t, n_errors);
        end
        summarize();
    end

    // Watchdog well beyond the expected 2100 cycles
    initial
    begin
        #(20 * 10000);
        n_errors++;
        summarize();
    end
endmodule : tb_alu_barrel_shifter_flags
